// File: design/psai_pkg.sv
// constants and types of the serial audio input front end
package psai_pkg;
    // interface formats (strap field values 0..3, register-only 4..5)
    localparam logic [2:0] FMT_LJ = 3'h0;
    localparam logic [2:0] FMT_I2S = 3'h1;
    localparam logic [2:0] FMT_RJ16 = 3'h2;
    localparam logic [2:0] FMT_RJ24 = 3'h3;
    localparam logic [2:0] FMT_RJ20 = 3'h4;
    localparam logic [2:0] FMT_RJ18 = 3'h5;
    // speed modes
    localparam logic [1:0] SPD_SINGLE = 2'h0;
    localparam logic [1:0] SPD_DOUBLE = 2'h1;
    localparam logic [1:0] SPD_QUAD = 2'h2;
    localparam logic [1:0] SPD_STREAM = 2'h3;
    // oversampling ratios
    localparam logic [7:0] OSR_SINGLE = 8'h80;
    localparam logic [7:0] OSR_DOUBLE = 8'h40;
    localparam logic [7:0] OSR_QUAD = 8'h20;
    // master clock ratio bounds per mode, in master clocks per frame
    localparam logic [11:0] RATIO_SS_MIN = 12'h100;
    localparam logic [11:0] RATIO_SS_MAX = 12'h300;
    localparam logic [11:0] RATIO_SS_DIV = 12'h400;
    localparam logic [11:0] RATIO_DS_MIN = 12'h080;
    localparam logic [11:0] RATIO_DS_MAX = 12'h180;
    localparam logic [11:0] RATIO_DS_DIV = 12'h200;
    localparam logic [11:0] RATIO_QS_MIN = 12'h040;
    localparam logic [11:0] RATIO_QS_MAX = 12'h0C0;
    localparam logic [11:0] RATIO_QS_DIV = 12'h100;
    localparam int WORD_W = 24;
    localparam int FIFO_DEPTH = 4;
endpackage

// File: design/psai_fifo.sv
// small valid/ready fifo for received audio words
`timescale 1ns/1ns
`default_nettype none
module psai_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    // pointers and fill level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// File: design/psai_core.sv
// serial audio input front end: strap decode, ratio detect, word capture
// How it works
// - words are received as two's complement, sign kept, right aligned to 24 bits
// - frame clock level picks which channel the arriving word belongs to
// - count master clocks over one frame period, then check the ratio against the speed mode limits
// - outside stream mode, top ratios accepted only under register control with divide bit set
// - strap pins sampled continually; changes applied
// - format straps: LJ, I2S, RJ16, RJ24
// - speed straps: single, single+deemphasis, double, quad
// - stream enable: upper strap picks 64x/128x, lower two the clock ratio
// - port is slave only; never drives bit or frame clock
// - data bits captured on bit clock rising edge
// - register formats add right-justified 20 and 18 bit
// - oversampling 128x single, 64x double, 32x quad
// - speed from straps when pin-strapped, from mode bits under register control
// - register control takes mode and format from register fields
// - configuration by straps or by register control select
// - register mode bits enter stream mode; format field sets stream ratio
// - mute output active in reset, init, mute request, bad ratio
`timescale 1ns/1ns
`default_nettype none
module psai_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic master_clock,
    input wire logic bit_clock,
    input wire logic frame_channel_clock,
    input wire logic [2:0] serial_audio_inputs,
    input wire logic strap_pin_0,
    input wire logic strap_pin_1,
    input wire logic strap_pin_2,
    input wire logic strap_pin_3,
    input wire logic direct_stream_enable_pin,
    input wire logic register_control,
    input wire logic [1:0] functional_mode_bits,
    input wire logic [3:0] interface_format_field,
    input wire logic master_clock_divide_bit,
    input wire logic mute_request,
    output logic [2:0] active_format,
    output logic [1:0] active_speed,
    output logic deemphasis_select,
    output logic direct_stream_bitstream,
    output logic stream_128x,
    output logic [3:0] stream_clock_ratio,
    output logic [7:0] oversample_ratio,
    output logic [11:0] measured_ratio,
    output logic ratio_ok,
    output logic mute_control_output,
    output logic word_valid,
    input wire logic word_ready,
    output logic [1:0] word_pair,
    output logic word_right,
    output logic [psai_pkg::WORD_W-1:0] word_data
);
    // two-flop synchronisers for all pin inputs
    localparam int NS = 11;
    logic [NS-1:0] sync_a;
    logic [NS-1:0] sync_b;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {master_clock, bit_clock, frame_channel_clock, serial_audio_inputs,
                strap_pin_0, strap_pin_1, strap_pin_2, strap_pin_3,
                direct_stream_enable_pin};
            sync_b <= sync_a;
        end
    end
    logic s_mclk, s_bclk, s_lr, s_m0, s_m1, s_m2, s_m3, s_dsen;
    logic [2:0] s_sd;
    assign {s_mclk, s_bclk, s_lr, s_sd, s_m0, s_m1, s_m2, s_m3, s_dsen} = sync_b;

    // delayed copies for edge detection
    logic d_mclk, d_bclk, d_lr;
    logic lr_bit; // frame level at the previous bit clock rise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            d_mclk <= 1'b0;
            d_bclk <= 1'b0;
            d_lr <= 1'b0;
        end else begin
            d_mclk <= s_mclk;
            d_bclk <= s_bclk;
            d_lr <= s_lr;
        end
    end
    logic mclk_rise, bclk_rise, lr_rise, lr_edge;
    assign mclk_rise = s_mclk && !d_mclk;
    assign bclk_rise = s_bclk && !d_bclk;
    assign lr_rise = s_lr && !d_lr;
    assign lr_edge = s_lr != lr_bit; // frame moves on the falling bit edge, seen at the next rise

    // configuration decode; straps re-read every cycle
    logic [2:0] next_format;
    logic [1:0] next_speed;
    logic next_deemph, next_stream, next_s128;
    logic [3:0] next_sratio;
    always_comb begin
        next_format = psai_pkg::FMT_LJ;
        next_speed = psai_pkg::SPD_SINGLE;
        next_deemph = 1'b0;
        next_stream = 1'b0;
        next_s128 = 1'b0;
        next_sratio = 4'h4;
        if (register_control) begin
            next_format = interface_format_field[2:0];
            if (next_format > psai_pkg::FMT_RJ18) begin
                next_format = psai_pkg::FMT_LJ; // codes 6 and 7 act as 24-bit left justified
            end
            next_speed = functional_mode_bits;
            if (functional_mode_bits == psai_pkg::SPD_STREAM) begin
                next_stream = 1'b1;
                next_s128 = interface_format_field[2];
                next_sratio = stream_ratio(interface_format_field[2], interface_format_field[1:0]);
            end
        end else if (s_dsen) begin
            next_stream = 1'b1;
            next_speed = psai_pkg::SPD_STREAM;
            next_s128 = s_m2;
            next_sratio = stream_ratio(s_m2, {s_m1, s_m0});
        end else begin
            next_format = {1'b0, s_m1, s_m0};
            unique case ({s_m3, s_m2})
                2'h0: next_speed = psai_pkg::SPD_SINGLE;
                2'h1: begin
                    next_speed = psai_pkg::SPD_SINGLE;
                    next_deemph = 1'b1;
                end
                2'h2: next_speed = psai_pkg::SPD_DOUBLE;
                2'h3: next_speed = psai_pkg::SPD_QUAD;
            endcase
        end
    end

    function automatic logic [3:0] stream_ratio(input logic hi, input logic [1:0] sel);
        logic [3:0] r;
        unique case (sel)
            2'h0: r = hi ? 4'h2 : 4'h4;
            2'h1: r = hi ? 4'h3 : 4'h6;
            2'h2: r = hi ? 4'h4 : 4'h8;
            default: r = hi ? 4'h6 : 4'hC;
        endcase
        return r;
    endfunction

    // registered configuration outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_format <= psai_pkg::FMT_LJ;
            active_speed <= psai_pkg::SPD_SINGLE;
            deemphasis_select <= 1'b0;
            direct_stream_bitstream <= 1'b0;
            stream_128x <= 1'b0;
            stream_clock_ratio <= 4'h4;
            oversample_ratio <= psai_pkg::OSR_SINGLE;
        end else begin
            active_format <= next_format;
            active_speed <= next_speed;
            deemphasis_select <= next_deemph;
            direct_stream_bitstream <= next_stream;
            stream_128x <= next_s128;
            stream_clock_ratio <= next_sratio;
            unique case (next_speed)
                psai_pkg::SPD_DOUBLE: oversample_ratio <= psai_pkg::OSR_DOUBLE;
                psai_pkg::SPD_QUAD: oversample_ratio <= psai_pkg::OSR_QUAD;
                default: oversample_ratio <= psai_pkg::OSR_SINGLE;
            endcase
        end
    end

    // master clocks per frame: counted between frame rising edges
    logic [11:0] mcount;
    logic measured;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mcount <= '0;
            measured_ratio <= '0;
            measured <= 1'b0;
        end else if (lr_rise) begin
            mcount <= 12'(mclk_rise);
            measured_ratio <= mcount;
            measured <= 1'b1;
        end else if (mclk_rise && mcount != 12'hFFF) begin
            mcount <= mcount + 12'h001;
        end
    end

    // ratio check against the selected speed
    function automatic logic ratio_legal(input logic [11:0] r, input logic [1:0] spd,
        input logic divok);
        logic [11:0] lo, hi, top;
        lo = psai_pkg::RATIO_SS_MIN;
        hi = psai_pkg::RATIO_SS_MAX;
        top = psai_pkg::RATIO_SS_DIV;
        if (spd == psai_pkg::SPD_DOUBLE) begin
            lo = psai_pkg::RATIO_DS_MIN;
            hi = psai_pkg::RATIO_DS_MAX;
            top = psai_pkg::RATIO_DS_DIV;
        end else if (spd == psai_pkg::SPD_QUAD) begin
            lo = psai_pkg::RATIO_QS_MIN;
            hi = psai_pkg::RATIO_QS_MAX;
            top = psai_pkg::RATIO_QS_DIV;
        end
        return (r >= lo && r <= hi) || (divok && r == top);
    endfunction

    logic next_ok;
    assign next_ok = measured && (direct_stream_bitstream ||
        ratio_legal(measured_ratio, active_speed, register_control && master_clock_divide_bit));
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ratio_ok <= 1'b0;
            mute_control_output <= 1'b1;
        end else begin
            ratio_ok <= next_ok;
            mute_control_output <= !next_ok || mute_request;
        end
    end

    // per-pair shift registers; left/right from frame level
    logic [psai_pkg::WORD_W-1:0] shreg [3];
    logic [4:0] bitcnt;
    logic cur_right;
    logic i2s;
    assign i2s = active_format == psai_pkg::FMT_I2S;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                shreg[i] <= '0;
            end
            bitcnt <= '0;
            cur_right <= 1'b0;
            lr_bit <= 1'b0;
        end else if (bclk_rise) begin
            for (int i = 0; i < 3; i++) begin
                shreg[i] <= lr_edge ? {{(psai_pkg::WORD_W-1){1'b0}}, s_sd[i]}
                                    : {shreg[i][psai_pkg::WORD_W-2:0], s_sd[i]};
            end
            bitcnt <= lr_edge ? 5'h01 : (bitcnt == 5'h1F ? bitcnt : bitcnt + 5'h01);
            cur_right <= i2s ? s_lr : !s_lr;
            lr_bit <= s_lr;
        end
    end

    // word length for the current format
    function automatic logic [4:0] word_len(input logic [2:0] f);
        unique case (f)
            psai_pkg::FMT_RJ16: return 5'h10;
            psai_pkg::FMT_RJ20: return 5'h14;
            psai_pkg::FMT_RJ18: return 5'h12;
            default: return 5'h18;
        endcase
    endfunction

    // a word completes on a frame edge (right justified) or after its length (others)
    logic rj, word_done;
    logic [4:0] wl;
    logic [psai_pkg::WORD_W-1:0] aligned [3];
    logic i2s_skip;
    assign rj = active_format >= psai_pkg::FMT_RJ16;
    assign wl = word_len(active_format);
    assign i2s_skip = i2s ? 1'b1 : 1'b0;
    assign word_done = bclk_rise && !direct_stream_bitstream && (rj ? lr_edge
        : (!lr_edge && bitcnt == wl + 5'(i2s_skip) - 5'h01));
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            aligned[i] = sign_ext(rj ? shreg[i] : {shreg[i][psai_pkg::WORD_W-2:0], s_sd[i]}, wl);
        end
    end

    // sign-extend the low n bits of a word
    function automatic logic [psai_pkg::WORD_W-1:0] sign_ext(
        input logic [psai_pkg::WORD_W-1:0] w, input logic [4:0] n);
        logic [psai_pkg::WORD_W-1:0] r;
        r = w;
        for (int b = 0; b < psai_pkg::WORD_W; b++) begin
            if (5'(b) >= n) begin
                r[b] = w[n - 5'h01];
            end
        end
        return r;
    endfunction

    // three pair words queued to the fifo one after another
    logic [psai_pkg::WORD_W-1:0] hold [3];
    logic [1:0] pend;
    logic hold_right;
    logic f_ready, f_valid;
    logic [psai_pkg::WORD_W+2:0] f_out;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                hold[i] <= '0;
            end
            pend <= 2'h0;
            hold_right <= 1'b0;
        end else if (word_done) begin
            hold <= aligned; // a new word overruns any still pending
            pend <= 2'h3;
            hold_right <= rj ? (i2s ? lr_bit : !lr_bit) : cur_right;
        end else if (pend != 2'h0 && f_ready) begin
            pend <= pend - 2'h1;
        end
    end
    logic [1:0] pair_idx;
    assign pair_idx = 2'h3 - pend;

    psai_fifo #(.WIDTH(psai_pkg::WORD_W + 3), .DEPTH(psai_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(pend != 2'h0 && !word_done),
        .in_ready(f_ready),
        .in_data({pair_idx, hold_right, hold[pair_idx]}),
        .out_valid(f_valid),
        .out_ready(word_ready && !word_valid),
        .out_data(f_out)
    );

    // output register stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            word_valid <= 1'b0;
            word_pair <= 2'h0;
            word_right <= 1'b0;
            word_data <= '0;
        end else if (word_valid) begin
            word_valid <= 1'b0;
        end else if (f_valid && word_ready) begin
            word_valid <= 1'b1;
            {word_pair, word_right, word_data} <= f_out;
        end
    end

    // checks
    a_mute_bad_ratio: assert property (@(posedge clk) disable iff (!resetn)
        !next_ok |=> mute_control_output) else $error("mute not raised on bad ratio");
    a_strap_fmt: assert property (@(posedge clk) disable iff (!resetn)
        (!register_control && !s_dsen) |=> active_format == {1'b0, $past(s_m1), $past(s_m0)})
        else $error("strap format not applied");
    a_osr_quad: assert property (@(posedge clk) disable iff (!resetn)
        active_speed == psai_pkg::SPD_QUAD |-> oversample_ratio == psai_pkg::OSR_QUAD)
        else $error("quad speed oversampling wrong");
    a_stream_ratio: assert property (@(posedge clk) disable iff (!resetn)
        (!register_control && s_dsen && s_m2 && s_m1 && s_m0) |=> stream_clock_ratio == 4'h6)
        else $error("stream ratio wrong");
    a_ratio_capture: assert property (@(posedge clk) disable iff (!resetn)
        lr_rise |=> measured_ratio == $past(mcount)) else $error("ratio not captured");
    a_div_gate: assert property (@(posedge clk) disable iff (!resetn)
        (measured && measured_ratio == psai_pkg::RATIO_SS_DIV && active_speed ==
        psai_pkg::SPD_SINGLE && !direct_stream_bitstream && !register_control) |=> !ratio_ok)
        else $error("divide ratio accepted without register control");
    a_reg_speed: assert property (@(posedge clk) disable iff (!resetn)
        register_control |=> active_speed == $past(functional_mode_bits))
        else $error("register speed not applied");
    a_bit_capture: assert property (@(posedge clk) disable iff (!resetn)
        (bclk_rise && !lr_edge) |=> shreg[0][0] == $past(s_sd[0]))
        else $error("bit not taken on rising edge");
endmodule
`default_nettype wire

// File: sim/psai_source.sv
// audio source model: master, bit and frame clocks and three data lines
`timescale 1ns/1ns
`default_nettype none
module psai_source (
    input wire logic run,
    input wire logic [4:0] div,
    input wire logic [2:0] fmt,
    input wire logic [7:0][2:0][23:0] tx,
    output logic busy,
    output logic master_clock,
    output logic bit_clock,
    output logic frame_channel_clock,
    output logic [2:0] serial_audio_inputs
);
    // bit b of half k on line p, msb first; filler bits are inverted so they never look valid
    function automatic logic line_bit(input int k, input int b, input int p);
        int n;
        int i;
        n = (fmt == 3'h2) ? 16 : (fmt == 3'h4) ? 20 : (fmt == 3'h5) ? 18 : 24;
        i = (fmt < 3'h2) ? b - int'(fmt) : b + n - 32;
        if (i < 0) return ~tx[k][p][n - 1];
        return (i < n) ? tx[k][p][n - 1 - i] : ~tx[k][p][0];
    endfunction

    // put half k bit b on the wires; even halves are left, left is high except in i2s
    task automatic put(input int k, input int b);
        frame_channel_clock = (fmt == 3'h1) ^ ~k[0];
        for (int p = 0; p < 3; p++) serial_audio_inputs[p] = line_bit(k, b, p);
    endtask

    // clocks stand still between runs; one bit lasts 2*div master half periods
    initial begin
        busy = 1'b0;
        master_clock = 1'b0;
        bit_clock = 1'b0;
        frame_channel_clock = 1'b0;
        serial_audio_inputs = 3'h0;
        forever begin
            wait (run);
            busy = 1'b1;
            put(0, 0);
            for (int s = 0; s < 256; s++) begin
                for (int h = 0; h < 2 * div; h++) begin
                    master_clock = (h % 2 == 0);
                    bit_clock = (h < div);
                    if (h == div && s < 255) put((s + 1) / 32, (s + 1) % 32);
                    #50;
                end
            end
            serial_audio_inputs = ~serial_audio_inputs; // released lines flip
            busy = 1'b0;
            wait (!run);
        end
    end
endmodule
`default_nettype wire

// File: sim/pcm_dsd_serial_audio_input_tb_top.sv
// self-checking bench for the serial audio input front end
`timescale 1ns/1ns
`default_nettype none
module pcm_dsd_serial_audio_input_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic run = 1'b0;
    logic stall = 1'b0;
    logic word_ready = 1'b1;
    logic register_control = 1'b0;
    logic direct_stream_enable_pin = 1'b0;
    logic master_clock_divide_bit = 1'b0;
    logic mute_request = 1'b0;
    logic [1:0] functional_mode_bits = 2'h0;
    logic [3:0] interface_format_field = 4'h0;
    logic [3:0] strap = 4'h0;
    logic [4:0] div = 5'h04;
    logic [2:0] sfmt = 3'h0;
    logic [7:0][2:0][23:0] tx = '0;
    logic busy, master_clock, bit_clock, frame_channel_clock, deemphasis_select;
    logic direct_stream_bitstream, stream_128x, ratio_ok, mute_control_output;
    logic word_valid, word_right;
    logic [2:0] serial_audio_inputs, active_format;
    logic [1:0] active_speed, word_pair;
    logic [3:0] stream_clock_ratio;
    logic [7:0] oversample_ratio;
    logic [11:0] measured_ratio;
    logic [23:0] word_data;
    logic [26:0] rxq[$];
    int failures = 0;
    int n_checks = 0;

    psai_core DUT (
        .clk, .resetn, .master_clock, .bit_clock, .frame_channel_clock, .serial_audio_inputs,
        .strap_pin_0(strap[0]), .strap_pin_1(strap[1]), .strap_pin_2(strap[2]),
        .strap_pin_3(strap[3]), .direct_stream_enable_pin, .register_control,
        .functional_mode_bits, .interface_format_field, .master_clock_divide_bit, .mute_request,
        .active_format, .active_speed, .deemphasis_select, .direct_stream_bitstream,
        .stream_128x, .stream_clock_ratio, .oversample_ratio, .measured_ratio, .ratio_ok,
        .mute_control_output, .word_valid, .word_ready, .word_pair, .word_right, .word_data
    );
    psai_source src (
        .run, .busy, .div, .fmt(sfmt), .tx, .master_clock, .bit_clock, .frame_channel_clock,
        .serial_audio_inputs
    );

    // 100 MHz system clock
    always #5 clk = ~clk;

    // collect delivered words; the sink hesitates at random and can be stalled
    always @(posedge clk) begin
        if (word_valid === 1'b1) rxq.push_back({word_right, word_pair, word_data});
        #1 word_ready = !stall && ($urandom % 4 != 0);
    end

    // compare one value, count it and report a mismatch
    task automatic check(input logic [26:0] seen, input logic [26:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // print the counts and the verdict, then end the run
    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // bounded wait on the source model; running out counts as a mismatch
    task automatic wait_busy(input logic lvl, input int lim);
        int c;
        c = 0;
        while (busy !== lvl && c < lim) begin
            @(posedge clk);
            c++;
        end
        if (c >= lim) begin
            failures++;
            stop_test();
        end
    endtask

    // word as delivered: right-justified formats sign-extend from their length
    function automatic logic [23:0] exp_word(input logic [23:0] w, input logic [2:0] f);
        case (f)
            psai_pkg::FMT_RJ16: return {{8{w[15]}}, w[15:0]};
            psai_pkg::FMT_RJ20: return {{4{w[19]}}, w[19:0]};
            psai_pkg::FMT_RJ18: return {{6{w[17]}}, w[17:0]};
            default: return w;
        endcase
    endfunction

    // decoded configuration expected from the present straps or register fields
    task automatic check_cfg;
        logic rc;
        logic st;
        logic hi;
        logic [1:0] sp;
        logic [1:0] ri;
        logic [2:0] f;
        logic [15:0] rt;
        rc = register_control;
        st = rc ? (functional_mode_bits == 2'h3) : direct_stream_enable_pin;
        sp = rc ? functional_mode_bits : (strap[3] ? {strap[2], ~strap[2]} : 2'h0);
        f = rc ? interface_format_field[2:0] : {1'b0, strap[1:0]};
        hi = rc ? interface_format_field[2] : strap[2];
        ri = rc ? interface_format_field[1:0] : strap[1:0];
        rt = hi ? 16'h6432 : 16'hC864;
        if (f > 3'h5) f = psai_pkg::FMT_LJ;
        check(27'(direct_stream_bitstream), 27'(st));
        if (st) begin
            check(27'(active_speed), 27'(psai_pkg::SPD_STREAM));
            check(27'(stream_128x), 27'(hi));
            check(27'(stream_clock_ratio), 27'(rt[ri * 4 +: 4]));
        end else begin
            check(27'(active_speed), 27'(sp));
            check(27'(active_format), 27'(f));
            check(27'(oversample_ratio), 27'(8'h80 >> sp));
            if (!rc) check(27'(deemphasis_select), 27'(strap[3:2] == 2'h1));
        end
    endtask

    // set the configuration inputs just after an edge and let them settle
    task automatic cfg(input logic [3:0] s, input logic rc, input logic [1:0] fm,
        input logic [3:0] ff, input logic md);
        @(posedge clk);
        #1 strap = s;
        direct_stream_enable_pin = 1'b0;
        register_control = rc;
        functional_mode_bits = fm;
        interface_format_field = ff;
        master_clock_divide_bit = md;
        repeat (4) @(posedge clk);
    endtask

    // send four frames, halves 1 to 6 carrying the test words, then compare those words, ratio and mute state
    task automatic run_audio(input logic [2:0] f, input logic [4:0] d, input logic ok,
        input logic st);
        int j;
        j = 0;
        sfmt = f;
        div = d;
        for (int i = 1; i < 7; i++) tx[i] = 72'({$urandom, $urandom, $urandom});
        tx[2] = {24'h800000, 24'h7FFFFF, 24'h008000};
        rxq.delete();
        #1 run = 1'b1;
        wait_busy(1'b1, 100);
        run = 1'b0;
        if (st) begin
            repeat (960 * d) @(posedge clk);
            #1 stall = 1'b1;
            repeat (480 * d) @(posedge clk);
            #1 stall = 1'b0;
        end
        wait_busy(1'b0, 2700 * d);
        repeat (200) @(posedge clk);
        for (int i = rxq.size() - 1; i >= 0; i--) begin
            if (rxq[i] === {1'b1, 2'h0, exp_word(tx[1][0], f)}) j = i;
        end
        for (int k = 1; k < 7; k++) begin
            for (int p = 0; p < 3; p++) begin
                check(rxq[j], {1'(k % 2), 2'(p), exp_word(tx[k][p], f)});
                j++;
            end
        end
        check(27'(measured_ratio), 27'(d) * 27'h40);
        check(27'(ratio_ok), 27'(ok));
        check(27'(mute_control_output), 27'(!ok));
    endtask

    // reset, configuration sweep, audio runs, mute request
    initial begin
        void'($urandom(13));
        repeat (4) @(posedge clk);
        #1 check(27'(mute_control_output), 27'h1);
        check(27'(measured_ratio), 27'h0);
        resetn = 1'b1;
        for (int i = 0; i < 64; i++) begin
            {direct_stream_enable_pin, strap, functional_mode_bits} = 7'($urandom);
            interface_format_field = 4'($urandom);
            register_control = i[5];
            if (i[5]) {functional_mode_bits, interface_format_field[2:0]} = 5'(i);
            else {direct_stream_enable_pin, strap} = 5'(i);
            repeat (3) @(posedge clk);
            #1 check_cfg();
        end
        cfg(4'h0, 1'b0, 2'h0, 4'h0, 1'b0);
        run_audio(psai_pkg::FMT_LJ, 5'h04, 1'b1, 1'b1);
        cfg(4'h5, 1'b0, 2'h0, 4'h0, 1'b0);
        run_audio(psai_pkg::FMT_I2S, 5'h06, 1'b1, 1'b0);
        cfg(4'hA, 1'b0, 2'h0, 4'h0, 1'b0);
        run_audio(psai_pkg::FMT_RJ16, 5'h02, 1'b1, 1'b0);
        cfg(4'hF, 1'b0, 2'h0, 4'h0, 1'b0);
        run_audio(psai_pkg::FMT_RJ24, 5'h01, 1'b1, 1'b0);
        cfg(4'h0, 1'b0, 2'h0, 4'h0, 1'b0);
        run_audio(psai_pkg::FMT_LJ, 5'h02, 1'b0, 1'b0);
        cfg(4'h0, 1'b1, 2'h0, 4'h4, 1'b0);
        run_audio(psai_pkg::FMT_RJ20, 5'h04, 1'b1, 1'b0);
        cfg(4'hF, 1'b1, 2'h1, 4'h5, 1'b0);
        run_audio(psai_pkg::FMT_RJ18, 5'h03, 1'b1, 1'b0);
        cfg(4'h0, 1'b1, 2'h2, 4'h0, 1'b0);
        run_audio(psai_pkg::FMT_LJ, 5'h04, 1'b0, 1'b0);
        cfg(4'h0, 1'b1, 2'h2, 4'h0, 1'b1);
        run_audio(psai_pkg::FMT_LJ, 5'h04, 1'b1, 1'b0);
        #1 mute_request = 1'b1;
        repeat (4) @(posedge clk);
        #1 check(27'(mute_control_output), 27'h1);
        mute_request = 1'b0;
        repeat (4) @(posedge clk);
        #1 check(27'(mute_control_output), 27'h0);
        stop_test();
    end

    // cuts a hang short; the whole sequence needs about 0.8 ms
    initial begin
        #1500000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
